// ===== pkg/uart_match_pkg.sv
/*
 Register indices, field positions, reset values and counts for the
 ninth-bit, pin-control and address-match register block.
 Assumes a 32-bit Avalon-MM bus with one aligned word per register.
*/
package uart_match_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] CTRL_THREE_IDX = 4'h6;
    localparam logic [3:0] DATA_PORT_IDX = 4'h7;
    localparam logic [3:0] MATCH_ONE_IDX = 4'h8;
    localparam logic [3:0] MATCH_TWO_IDX = 4'h9;
    localparam int ADDR_W = 6;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;

    // Fields of control_three
    localparam int RX_NINTH_POS = 7;
    localparam int TX_NINTH_POS = 6;
    localparam int TX_DIR_POS = 5;
    localparam int TX_FLIP_POS = 4;
    localparam int ERR_EN_W = 4;

    // Error enable order: overrun, noise, framing, parity in bits 3..0
    localparam int OVERRUN_POS = 3;
    localparam int NOISE_POS = 2;
    localparam int FRAMING_POS = 1;
    localparam int PARITY_POS = 0;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;
    localparam logic TRANSFER_TYPE_CHAR = 1'b0;
    localparam logic TRANSFER_TYPE_BLOCK = 1'b1;
    localparam int TAIL_CHARS = 4;
    localparam int NINTH_POS = 8;
    localparam int MSB_EIGHT_POS = 7;
endpackage

// ===== design/uart_ninth_bit_match_ctrl.sv
/*
 Control register three, data port and the two match-address registers of
 the asynchronous serial port, with the ninth-bit path, transmit pin
 direction and polarity, receive filtering and the error request.
 Assumes the receiver, transmitter shifter and status flags live outside and
 talk through the plain ports below, all synchronous to core_clk.
*/
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module uart_ninth_bit_match_ctrl #(
    parameter int TAIL_COUNT = uart_match_pkg::TAIL_CHARS
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [uart_match_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic nineBitSelect,
    input wire logic tenBitSelect,
    input wire logic matchEnableOne,
    input wire logic matchEnableTwo,
    input wire logic smartcardEnable,
    input wire logic transferType,
    input wire logic initCharEnable,
    input wire logic initCharSeen,
    input wire logic blockLengthZero,
    input wire logic txCharDone,
    input wire logic nackSending,
    input wire logic singleWireMode,
    input wire logic loopbackMode,
    input wire logic rxPolarityFlip,
    input wire logic rxWordValid,
    input wire logic [8:0] rxWord,
    input wire logic rxPinLevel,
    input wire logic txRawLevel,
    input wire logic txDataBitPhase,
    input wire logic overrunFlag,
    input wire logic noiseFlag,
    input wire logic framingFlag,
    input wire logic parityFlag,
    output logic rxFull,
    output logic txLoad,
    output logic [7:0] txData,
    output logic txNinthBit,
    output logic txPin,
    output logic txPinOe,
    output logic rxLine,
    output logic errIrq
);
    import uart_match_pkg::*;

    localparam int CNT_W = $clog2(TAIL_COUNT + 1);

    if (TAIL_COUNT < 1) begin : g_bad_tail
        $error("TAIL_COUNT must be at least one");
    end

    logic waitQ;
    logic [31:0] readQ;
    logic rxNinthQ;
    logic txNinthHoldQ;
    logic txDirQ;
    logic txFlipQ;
    logic [ERR_EN_W-1:0] errEnQ;
    logic [7:0] rxDataQ;
    logic rxFullQ;
    logic [7:0] matchOneQ;
    logic [7:0] matchTwoQ;
    logic txLoadQ;
    logic [7:0] txDataQ;
    logic txNinthQ;
    logic txPinQ;
    logic txPinOeQ;
    logic rxLineQ;
    logic errIrqQ;
    logic [CNT_W-1:0] tailCntQ;
    logic [CNT_W-1:0] tailCntD;

    // Bus decode
    wire [3:0] regIdx = avs_address[IDX_MSB:IDX_LSB];
    wire accept = (avs_read | avs_write) & ~waitQ;
    wire wrLane = avs_write & accept & avs_byteenable[0];
    wire rdTake = avs_read & accept;
    wire wrCtrl = wrLane & (regIdx == CTRL_THREE_IDX);
    wire wrData = wrLane & (regIdx == DATA_PORT_IDX);
    wire wrMatchOne = wrLane & (regIdx == MATCH_ONE_IDX);
    wire wrMatchTwo = wrLane & (regIdx == MATCH_TWO_IDX);
    wire rdData = rdTake & (regIdx == DATA_PORT_IDX);
    wire [7:0] ctrlView = {rxNinthQ, txNinthHoldQ, txDirQ, txFlipQ, errEnQ};
    wire [7:0] rdMux = (regIdx == CTRL_THREE_IDX) ? ctrlView :
                       (regIdx == DATA_PORT_IDX) ? rxDataQ :
                       (regIdx == MATCH_ONE_IDX) ? matchOneQ :
                       (regIdx == MATCH_TWO_IDX) ? matchTwoQ : BYTE_RESET;

    // Receive filtering
    wire nineMode = nineBitSelect | tenBitSelect;
    wire wordMsb = nineMode ? rxWord[NINTH_POS] : rxWord[MSB_EIGHT_POS];
    wire anyMatch = matchEnableOne | matchEnableTwo;
    wire hitOne = matchEnableOne & (rxWord[7:0] == matchOneQ);
    wire hitTwo = matchEnableTwo & (rxWord[7:0] == matchTwoQ);
    wire keepWord = ~anyMatch | (wordMsb & (hitOne | hitTwo));
    wire storeWord = rxWordValid & keepWord;

    // Smartcard automatic actions
    wire blockMode = smartcardEnable & (transferType == TRANSFER_TYPE_BLOCK);
    wire charMode = smartcardEnable & (transferType == TRANSFER_TYPE_CHAR);
    wire tailStep = blockMode & blockLengthZero & txCharDone;
    wire tailDone = tailStep & (tailCntQ == CNT_W'(TAIL_COUNT - 1));
    wire flipAuto = charMode & initCharEnable & initCharSeen;

    // Pin levels
    wire flipNow = txFlipQ & (~smartcardEnable | txDataBitPhase);
    wire txLevel = txRawLevel ^ flipNow;
    wire dirNow = (charMode & nackSending) | txDirQ;
    wire [ERR_EN_W-1:0] errFlags = {overrunFlag, noiseFlag, framingFlag, parityFlag};

    assign tailCntD = ~blockMode ? '0 :
                      tailDone ? '0 :
                      tailStep ? tailCntQ + CNT_W'(1) : tailCntQ;

    // One wait cycle, then the answer; idle waitrequest stays high
    always_ff @(posedge core_clk) begin
        if (srst) begin
            waitQ <= 1'b1;
            readQ <= '0;
        end else begin
            waitQ <= ~((avs_read | avs_write) & waitQ);
            readQ <= {UPPER_ZERO, rdMux};
        end
    end

    // Control register three
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txNinthHoldQ <= 1'b0;
            txDirQ <= 1'b0;
            txFlipQ <= 1'b0;
            errEnQ <= '0;
        end else begin
            if (wrCtrl) begin
                txNinthHoldQ <= avs_writedata[TX_NINTH_POS];
                txDirQ <= avs_writedata[TX_DIR_POS];
                txFlipQ <= avs_writedata[TX_FLIP_POS];
                errEnQ <= avs_writedata[ERR_EN_W-1:0];
            end
            if (tailDone) begin
                txDirQ <= 1'b0;
            end
            if (flipAuto) begin
                txFlipQ <= 1'b1;
            end
        end
    end

    // Receive word and its ninth bit move together; bit 7 takes no writes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rxDataQ <= BYTE_RESET;
            rxNinthQ <= 1'b0;
            rxFullQ <= 1'b0;
            tailCntQ <= '0;
        end else begin
            if (storeWord) begin
                rxDataQ <= rxWord[7:0];
                rxNinthQ <= nineMode & rxWord[NINTH_POS];
            end
            // A word arriving with the read keeps the flag set
            rxFullQ <= storeWord | (rxFullQ & ~rdData);
            tailCntQ <= tailCntD;
        end
    end

    // Match registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            matchOneQ <= BYTE_RESET;
            matchTwoQ <= BYTE_RESET;
        end else begin
            if (wrMatchOne) begin
                matchOneQ <= avs_writedata[7:0];
            end
            if (wrMatchTwo) begin
                matchTwoQ <= avs_writedata[7:0];
            end
        end
    end

    // Transmit side: the held ninth bit is committed with the data word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txLoadQ <= 1'b0;
            txDataQ <= BYTE_RESET;
            txNinthQ <= 1'b0;
        end else begin
            txLoadQ <= wrData;
            if (wrData) begin
                txDataQ <= avs_writedata[7:0];
                txNinthQ <= txNinthHoldQ;
            end
        end
    end

    // Pins and request
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txPinQ <= 1'b1;
            txPinOeQ <= 1'b1;
            rxLineQ <= 1'b1;
            errIrqQ <= 1'b0;
        end else begin
            txPinQ <= txLevel;
            // Outside single-wire mode the pin is always driven
            txPinOeQ <= ~singleWireMode | dirNow;
            rxLineQ <= loopbackMode ? txLevel : rxPinLevel;
            errIrqQ <= |(errFlags & errEnQ);
        end
    end

    assign avs_readdata = readQ;
    assign avs_waitrequest = waitQ;
    assign rxFull = rxFullQ;
    assign txLoad = txLoadQ;
    assign txData = txDataQ;
    assign txNinthBit = txNinthQ;
    assign txPin = txPinQ;
    assign txPinOe = txPinOeQ;
    assign rxLine = rxLineQ;
    assign errIrq = errIrqQ;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    answer_one_wait_a: assert property (
        (avs_read | avs_write) && waitQ |=> !waitQ)
        else $error("answer not given after one wait cycle");

    ninth_rx_hold_a: assert property (
        wrCtrl && !storeWord |=> rxNinthQ == $past(rxNinthQ))
        else $error("write changed the received ninth bit");

    ninth_rx_load_a: assert property (
        storeWord && nineMode |=> rxNinthQ == $past(rxWord[NINTH_POS]))
        else $error("received ninth bit not captured");

    ninth_tx_commit_a: assert property (
        wrData |=> txNinthQ == $past(txNinthHoldQ))
        else $error("held ninth bit not committed with data");

    irq_error_mux_a: assert property (
        ##1 errIrqQ == |($past(errFlags) & $past(errEnQ)))
        else $error("error request does not follow enabled flags");

    flip_auto_set_a: assert property (
        flipAuto |=> txFlipQ)
        else $error("initial character did not set polarity flip");

    dir_tail_clear_a: assert property (
        tailDone && !wrCtrl |=> !txDirQ)
        else $error("pin direction not cleared after block tail");

    rx_full_clear_a: assert property (
        rdData && !storeWord |=> !rxFullQ)
        else $error("data port read did not clear receive full");

    match_discard_a: assert property (
        rxWordValid && anyMatch && !wordMsb && !rdData |=>
        rxDataQ == $past(rxDataQ) && rxFullQ == $past(rxFullQ))
        else $error("address-clear word was stored");

    write_keeps_rx_a: assert property (
        wrData && !storeWord |=> rxDataQ == $past(rxDataQ))
        else $error("data port write disturbed receive data");

    tx_ninth_keep_a: assert property (
        !wrData |=> txNinthQ == $past(txNinthQ))
        else $error("committed ninth bit changed without data write");

    card_idle_level_a: assert property (
        smartcardEnable && !txDataBitPhase |=> txPinQ == $past(txRawLevel))
        else $error("card mode flipped a non-data level");

    flip_all_level_a: assert property (
        !smartcardEnable && txFlipQ |=> txPinQ != $past(txRawLevel))
        else $error("polarity flip not applied to every level");

    loop_line_flip_a: assert property (
        loopbackMode && txFlipQ && !smartcardEnable |=> rxLineQ != $past(txRawLevel))
        else $error("loopback line does not carry flipped level");

    pin_line_follow_a: assert property (
        !loopbackMode |=> rxLineQ == $past(rxPinLevel))
        else $error("receive line does not follow receive pin");

    pin_input_dir_a: assert property (
        singleWireMode && !txDirQ && !nackSending |=> !txPinOeQ)
        else $error("single-wire pin driven while set as input");

    pin_output_dir_a: assert property (
        singleWireMode && txDirQ |=> txPinOeQ)
        else $error("single-wire pin not driven while set as output");

    nack_drive_a: assert property (
        singleWireMode && charMode && nackSending |=> txPinOeQ)
        else $error("pin not driven while a refusal is sent");

    nack_field_keep_a: assert property (
        nackSending && !wrCtrl && !tailDone |=> txDirQ == $past(txDirQ))
        else $error("refusal override leaked into direction field");

    match_one_write_a: assert property (
        wrMatchOne |=> matchOneQ == $past(avs_writedata[7:0]))
        else $error("first match register write lost");

    match_two_write_a: assert property (
        wrMatchTwo |=> matchTwoQ == $past(avs_writedata[7:0]))
        else $error("second match register write lost");

    rx_store_a: assert property (
        storeWord |=> rxFullQ && rxDataQ == $past(rxWord[7:0]))
        else $error("kept word not placed in receive data");

    tail_count_bound_a: assert property (
        tailCntQ < CNT_W'(TAIL_COUNT))
        else $error("block tail counter passed its end");
endmodule

// ===== test/remote_station.sv
/*
 Remote serial station: hands received words to the block as one-cycle pulses.
 Assumes the bench calls send from its main sequence, just after a clock edge.
*/
`timescale 1ns/1ns
module remote_station (
    input wire logic core_clk,
    output logic rxWordValid,
    output logic [8:0] rxWord,
    output logic rxPinLevel
);
    initial begin
        rxWordValid = 1'b0;
        rxWord = 9'h1FF;
        rxPinLevel = 1'b1;
    end
    // Released word lines show the inverse so a stale copy cannot pass
    task automatic send(input logic [8:0] w);
        @(posedge core_clk);
        rxWordValid <= 1'b1;
        rxWord <= w;
        @(posedge core_clk);
        rxWordValid <= 1'b0;
        rxWord <= ~w;
    endtask
    task automatic pin(input logic v);
        rxPinLevel <= v;
    endtask
endmodule

// ===== test/uart_ninth_bit_match_ctrl_bench.sv
/*
 Bench for the ninth-bit, pin-control and match register block.
 Assumes the remote station model supplies received words.
*/
`timescale 1ns/1ns
module uart_ninth_bit_match_ctrl_bench;
    import uart_match_pkg::*;
    logic core_clk, srst, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, flg;
    logic nineBitSelect, tenBitSelect, matchEnableOne, matchEnableTwo, smartcardEnable;
    logic transferType, initCharEnable, initCharSeen, blockLengthZero, txCharDone;
    logic nackSending, singleWireMode, loopbackMode, rxPolarityFlip, rxWordValid;
    logic rxPinLevel, txRawLevel, txDataBitPhase, rxFull, txLoad, txNinthBit;
    logic txPin, txPinOe, rxLine, errIrq;
    logic [8:0] rxWord;
    logic [7:0] txData;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    uart_ninth_bit_match_ctrl #(.TAIL_COUNT(TAIL_CHARS)) uut (
        .core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .nineBitSelect, .tenBitSelect,
        .matchEnableOne, .matchEnableTwo, .smartcardEnable, .transferType, .initCharEnable,
        .initCharSeen, .blockLengthZero, .txCharDone, .nackSending, .singleWireMode,
        .loopbackMode, .rxPolarityFlip, .rxWordValid, .rxWord, .rxPinLevel, .txRawLevel,
        .txDataBitPhase, .overrunFlag(flg[3]), .noiseFlag(flg[2]), .framingFlag(flg[1]),
        .parityFlag(flg[0]), .rxFull, .txLoad, .txData, .txNinthBit, .txPin, .txPinOe,
        .rxLine, .errIrq);
    remote_station station (.core_clk, .rxWordValid, .rxWord, .rxPinLevel);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run is well under a thousand cycles; the ceiling only cuts hangs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until waitrequest is sampled low; read data taken there
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string n);
        bus(1'b0, a, 8'h00);
        chk(n, e, rd & m);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, flg, nineBitSelect} = '0;
        {tenBitSelect, matchEnableOne, matchEnableTwo, smartcardEnable, transferType} = '0;
        {initCharEnable, initCharSeen, blockLengthZero, txCharDone, nackSending} = '0;
        {singleWireMode, loopbackMode, rxPolarityFlip, txRawLevel, txDataBitPhase} = '0;
        avs_byteenable = 4'hF;
        srst = 1'b1;
        tick(20);
        srst <= 1'b0;
        for (int i = 6; i < 11; i++) rdk(6'(i * 4), 32'hFFFFFFFF, 0, "reset");
        bus(1'b1, 6'h20, 8'hA5);
        bus(1'b1, 6'h24, 8'hDA);
        bus(1'b1, 6'h28, 8'hFF);
        avs_byteenable <= 4'hE;
        bus(1'b1, 6'h20, 8'h3C);
        avs_byteenable <= 4'hF;
        rdk(6'h20, 32'hFFFFFFFF, 32'hA5, "match one");
        rdk(6'h24, 32'hFFFFFFFF, 32'hDA, "match two");
        rdk(6'h28, 32'hFFFFFFFF, 0, "unmapped");
        bus(1'b1, 6'h18, 8'hFF);
        rdk(6'h18, 32'hBF, 32'h3F, "ctrl ro bit");
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 6'h18, 8'(1 << i));
            flg <= ~4'(1 << i);
            tick(2);
            chk("irq masked", 0, errIrq);
            flg <= 4'(1 << i);
            tick(2);
            chk("irq enabled", 1, errIrq);
        end
        flg <= 4'h0;
        $display("test error requests done");
        for (int s = 0; s < 3; s++) begin
            tenBitSelect <= (s == 2);
            nineBitSelect <= (s == 1);
            station.send(9'h1BC);
            tick(1);
            chk("rx full", 1, rxFull);
            rdk(6'h18, 32'h80, (s != 0) ? 32'h80 : 0, "rx ninth");
            rdk(6'h1C, 32'hFFFFFFFF, 32'hBC, "rx data");
            tick(1);
            chk("rx cleared", 0, rxFull);
        end
        $display("test receive done");
        bus(1'b1, 6'h18, 8'h40);
        tick(2);
        chk("tx ninth held", 0, txNinthBit);
        bus(1'b1, 6'h1C, 8'h55);
        tick(1);
        chk("tx load", 1, txLoad);
        chk("tx data", 32'h55, txData);
        chk("tx ninth", 1, txNinthBit);
        bus(1'b1, 6'h1C, 8'hAA);
        tick(2);
        chk("tx ninth kept", 1, txNinthBit);
        chk("tx data two", 32'hAA, txData);
        $display("test transmit done");
        singleWireMode <= 1'b1;
        txRawLevel <= 1'b1;
        bus(1'b1, 6'h18, 8'h00);
        tick(2);
        chk("pin input", 0, txPinOe);
        bus(1'b1, 6'h18, 8'h30);
        tick(2);
        chk("pin output", 1, txPinOe);
        chk("pin flipped", 0, txPin);
        station.pin(1'b0);
        tick(2);
        chk("rx pin line", 0, rxLine);
        station.pin(1'b1);
        loopbackMode <= 1'b1;
        tick(2);
        chk("loop line", 0, rxLine);
        smartcardEnable <= 1'b1;
        tick(2);
        chk("card idle", 1, txPin);
        txDataBitPhase <= 1'b1;
        tick(2);
        chk("card data", 0, txPin);
        bus(1'b1, 6'h18, 8'h00);
        nackSending <= 1'b1;
        tick(2);
        chk("nack drive", 1, txPinOe);
        rdk(6'h18, 32'h20, 0, "nack field");
        nackSending <= 1'b0;
        transferType <= 1'b1;
        blockLengthZero <= 1'b1;
        bus(1'b1, 6'h18, 8'h20);
        repeat (TAIL_CHARS) begin
            rdk(6'h18, 32'h20, 32'h20, "tail pending");
            txCharDone <= 1'b1;
            @(posedge core_clk);
            txCharDone <= 1'b0;
        end
        rdk(6'h18, 32'h20, 0, "tail cleared");
        {transferType, initCharEnable, initCharSeen} <= 3'b011;
        @(posedge core_clk);
        initCharSeen <= 1'b0;
        rdk(6'h18, 32'h10, 32'h10, "auto flip");
        $display("test pin control done");
        {smartcardEnable, initCharEnable, tenBitSelect, nineBitSelect} <= 4'h0;
        matchEnableOne <= 1'b1;
        station.send(9'h025);
        station.send(9'h0A6);
        tick(1);
        chk("msb clear dropped", 0, rxFull);
        station.send(9'h0A5);
        tick(1);
        chk("match kept", 1, rxFull);
        rdk(6'h1C, 32'hFFFFFFFF, 32'hA5, "match data");
        matchEnableOne <= 1'b0;
        matchEnableTwo <= 1'b1;
        station.send(9'h0A5);
        tick(1);
        chk("match two drop", 0, rxFull);
        station.send(9'h0DA);
        tick(1);
        chk("match two kept", 1, rxFull);
        $display("test match done");
        tally_and_finish();
    end
endmodule
